// *** lpa_defines.svh ***
// Constants shared by the sensor end and the controller end.
// Assumes inclusion by bare name from the sensor and controller files.
//
// What this block does
// - All pixels integrate over one common window.
// - 128-stage shift register steps start bit.
// - Controller starts cycle with start high.
// - Controller drops start before next edge.
// - Start rise raises hold, begins integrator reset.
// - One pixel presented per clock on output.
// - Integrators reset 18 clocks, integrate from 19.
// - Clock 129 flushes bit, output goes high-z.
// - Controller always supplies the 129th clock.
// - Next start after transfer time past 129.
// - Output high-z outside pixel output phase.
// - Transfer time at least 20 microseconds.
// - Integration is 110 periods plus transfer time.
`ifndef LPA_DEFINES_SVH
`define LPA_DEFINES_SVH

// ----------------------------------------------------------------------
// Timing and geometry
// ----------------------------------------------------------------------
`define LPA_PIXELS          128
`define LPA_RESET_CLOCKS    18
`define LPA_CLK_PERIOD_NS   8
`define LPA_TRANSFER_US     20
// Transfer time as 125 MHz cycles, rounded up.
`define LPA_TRANSFER_CYC \
  ((`LPA_TRANSFER_US * 1000 + `LPA_CLK_PERIOD_NS - 1) / `LPA_CLK_PERIOD_NS)
`define LPA_SENSOR_DIV      16
`define LPA_PIXEL_W         8

`endif

// *** lpa_pkg.sv ***
// Types shared by the controller end.
// Assumes nothing of its surroundings.
package lpa_pkg;
  typedef enum logic [1:0] {
    CTL_IDLE  = 2'b00,
    CTL_START = 2'b01,
    CTL_CLOCK = 2'b10,
    CTL_WAIT  = 2'b11
  } ctl_state_type;
endpackage

// *** lpa_link_if.sv ***
// Link between the sensor end and its controller.
// Assumes a testbench resolves the analog bus from its output enable.
`timescale 1ns/10ps
interface lpa_link_if #(parameter int PIXEL_W = 8);
  logic               sensor_clk_en;
  logic               start;
  logic [PIXEL_W-1:0] pixel_analog_out;
  logic               pixel_analog_oe_n;

  modport sensor (
    input  sensor_clk_en,
    input  start,
    output pixel_analog_out,
    output pixel_analog_oe_n
  );
  modport controller (
    output sensor_clk_en,
    output start,
    input  pixel_analog_out,
    input  pixel_analog_oe_n
  );
endinterface

// *** lpa_clock_div.sv ***
// Divider giving a one-cycle enable pulse every DIV clocks.
// Assumes a synchronous active-high reset.
`timescale 1ns/10ps
module lpa_clock_div #(
  parameter int DIV = 16
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  output logic      tick
);
  logic [15:0] count_r;

  // Count while running and pulse on wrap.
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      count_r <= 16'h0000;
      tick    <= 1'b0;
    end else if (count_r == 16'(DIV - 1)) begin
      count_r <= 16'h0000;
      tick    <= 1'b1;
    end else begin
      count_r <= count_r + 16'h0001;
      tick    <= 1'b0;
    end
  end
endmodule

// *** lpa_sensor.sv ***
// Sensor end: shift register sequencer, hold and integrator control.
// Assumes the controller keeps start to one sensor clock and sends 129.
`include "lpa_defines.svh"
`timescale 1ns/10ps
module lpa_sensor #(
  parameter int PIXELS  = `LPA_PIXELS,
  parameter int RESET_N = `LPA_RESET_CLOCKS,
  parameter int PIXEL_W = `LPA_PIXEL_W
) (
  input  wire logic               clk,
  input  wire logic               rst,
  lpa_link_if.sensor              link,
  input  wire logic [PIXEL_W-1:0] pixel_charge [PIXELS],
  output logic                    hold,
  output logic                    integ_reset,
  output logic                    integrating
);
  logic [PIXELS-1:0] shift_r;
  logic [7:0]        clk_count_r;
  logic              start_d_r;

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // The start bit moves one stage per sensor clock; the 129th edge drops
  // it out the end, which returns the logic to idle.
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_r <= '0;
    end else if (link.sensor_clk_en) begin
      shift_r <= {shift_r[PIXELS-2:0], link.start};
    end
  end

  // Clock count within a cycle drives the integrator reset window; the
  // 129th edge clears it so the next cycle starts from a known state.
  always_ff @(posedge clk) begin
    if (rst) begin
      clk_count_r <= 8'h00;
      start_d_r   <= 1'b0;
    end else if (link.sensor_clk_en) begin
      start_d_r <= link.start;
      if (link.start && !start_d_r) begin
        clk_count_r <= 8'h01;
      end else if (clk_count_r != 8'h00 && clk_count_r < 8'(PIXELS)) begin
        clk_count_r <= clk_count_r + 8'h01;
      end else begin
        clk_count_r <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Hold and integrator control
  // ----------------------------------------------------------------------
  // Hold rises with start for every pixel at once; integrators reset for
  // the first clocks and a common window opens afterwards.
  always_ff @(posedge clk) begin
    if (rst) begin
      hold        <= 1'b0;
      integ_reset <= 1'b0;
      integrating <= 1'b1;
    end else if (link.sensor_clk_en) begin
      if (link.start && !start_d_r) begin
        hold        <= 1'b1;
        integ_reset <= 1'b1;
        integrating <= 1'b0;
      end else if (clk_count_r == 8'(RESET_N)) begin
        hold        <= 1'b0;
        integ_reset <= 1'b0;
        integrating <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Output
  // ----------------------------------------------------------------------
  // The active stage selects one pixel; no stage means high impedance.
  always_ff @(posedge clk) begin
    if (rst) begin
      link.pixel_analog_out  <= '0;
      link.pixel_analog_oe_n <= 1'b1;
    end else begin
      link.pixel_analog_out  <= '0;
      link.pixel_analog_oe_n <= 1'b1;
      for (int i = 0; i < PIXELS; i++) begin
        if (shift_r[i]) begin
          link.pixel_analog_out  <= pixel_charge[i];
          link.pixel_analog_oe_n <= 1'b0;
        end
      end
    end
  end
endmodule

// *** lpa_controller.sv ***
// Controller end: issues start and 129 sensor clocks, captures pixels.
// Assumes the sensor end shares clk and the link interface.
`include "lpa_defines.svh"
`timescale 1ns/10ps
module lpa_controller #(
  parameter int PIXELS   = `LPA_PIXELS,
  parameter int PIXEL_W  = `LPA_PIXEL_W,
  parameter int DIV      = `LPA_SENSOR_DIV,
  parameter int TRANSFER = `LPA_TRANSFER_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst,
  lpa_link_if.controller          link,
  input  wire logic               go,
  output logic                    busy,
  output logic                    pixel_valid,
  output logic [PIXEL_W-1:0]      pixel_data,
  output logic [7:0]              pixel_index
);
  lpa_pkg::ctl_state_type state_r;
  logic        tick;
  logic [7:0]  edge_count_r;
  logic [15:0] wait_r;
  logic        tick_d_r;
  logic        settle_r;

  lpa_clock_div #(.DIV(DIV)) u_div (
    .clk  (clk),
    .rst  (rst),
    .run  (state_r == lpa_pkg::CTL_START || state_r == lpa_pkg::CTL_CLOCK),
    .tick (tick)
  );

  // ----------------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------------
  // Start stands for one sensor clock, then 128 more edges, then a wait
  // of the transfer time before the next cycle may start.
  // Start drops on the very edge at which the sensor sees the enable, so
  // that edge captures it and the next one cannot capture it again.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r      <= lpa_pkg::CTL_IDLE;
      link.start   <= 1'b0;
      edge_count_r <= 8'h00;
      wait_r       <= 16'h0000;
      busy         <= 1'b0;
    end else begin
      case (state_r)
        lpa_pkg::CTL_IDLE: begin
          busy <= 1'b0;
          if (go) begin
            link.start <= 1'b1;
            busy       <= 1'b1;
            state_r    <= lpa_pkg::CTL_START;
          end
        end
        lpa_pkg::CTL_START: begin
          if (link.sensor_clk_en) begin
            link.start   <= 1'b0;
            edge_count_r <= 8'h01;
            state_r      <= lpa_pkg::CTL_CLOCK;
          end
        end
        lpa_pkg::CTL_CLOCK: begin
          if (link.sensor_clk_en) begin
            edge_count_r <= edge_count_r + 8'h01;
            if (edge_count_r == 8'(PIXELS)) begin
              wait_r  <= 16'h0000;
              state_r <= lpa_pkg::CTL_WAIT;
            end
          end
        end
        lpa_pkg::CTL_WAIT: begin
          wait_r <= wait_r + 16'h0001;
          if (wait_r == 16'(TRANSFER - 1)) begin
            state_r <= lpa_pkg::CTL_IDLE;
          end
        end
        default: state_r <= lpa_pkg::CTL_IDLE;
      endcase
    end
  end

  // Sensor clock enable is the divider tick, registered.
  always_ff @(posedge clk) begin
    if (rst) begin
      link.sensor_clk_en <= 1'b0;
    end else begin
      link.sensor_clk_en <= tick;
    end
  end

  // ----------------------------------------------------------------------
  // Pixel capture
  // ----------------------------------------------------------------------
  // A sensor edge moves the shift register, the next clock loads the
  // output, so the pixel is taken two clocks after the edge. Edge 129
  // releases the output, so only pixels 1..128 are ever strobed.
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_d_r    <= 1'b0;
      settle_r    <= 1'b0;
      pixel_valid <= 1'b0;
      pixel_data  <= '0;
      pixel_index <= 8'h00;
    end else begin
      tick_d_r    <= link.sensor_clk_en;
      settle_r    <= tick_d_r;
      pixel_valid <= 1'b0;
      if (settle_r && !link.pixel_analog_oe_n &&
          state_r == lpa_pkg::CTL_CLOCK) begin
        pixel_valid <= 1'b1;
        pixel_data  <= link.pixel_analog_out;
        pixel_index <= edge_count_r - 8'h01;
      end
    end
  end
endmodule

// *** lpa_link_monitor.sv ***
// Checker for the link between the sensor end and the controller end.
// Assumes it is instantiated beside the link, on the shared clock.
`timescale 1ns/10ps
module lpa_link_monitor #(
  parameter int PIXELS   = 128,
  parameter int TRANSFER = 2500,
  parameter int PIXEL_W  = 8
) (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               sensor_clk_en,
  input wire logic               start,
  input wire logic [PIXEL_W-1:0] pixel_analog_out,
  input wire logic               pixel_analog_oe_n
);
  logic [7:0]  edge_cnt_r;
  logic [11:0] gap_r;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Counts sensor edges of a cycle; the 129th edge returns it to zero.
  always_ff @(posedge clk) begin
    if (rst)
      edge_cnt_r <= 8'h00;
    else if (sensor_clk_en && start)
      edge_cnt_r <= 8'h01;
    else if (sensor_clk_en && edge_cnt_r != 8'h00)
      edge_cnt_r <= (edge_cnt_r == 8'(PIXELS)) ? 8'h00 : edge_cnt_r + 8'h01;
  end

  // Clocks since the last terminating edge, saturating when idle.
  always_ff @(posedge clk) begin
    if (rst)
      gap_r <= 12'hFFF;
    else if (sensor_clk_en && edge_cnt_r == 8'(PIXELS))
      gap_r <= 12'h000;
    else if (gap_r != 12'hFFF)
      gap_r <= gap_r + 12'h001;
  end

  a_tick_is_pulse: assert property (
    sensor_clk_en |=> !sensor_clk_en[*8])
    else $error("sensor clock enable too long");
  a_start_captured: assert property (
    $rose(start) |-> ##[1:40] (start && sensor_clk_en))
    else $error("start never captured");
  a_start_one_bit: assert property (
    sensor_clk_en && start |=> !start[*8])
    else $error("start held past capture");
  a_start_when_idle: assert property (
    sensor_clk_en && start |-> edge_cnt_r == 8'h00)
    else $error("start before terminating edge");
  a_output_driven: assert property (
    sensor_clk_en && edge_cnt_r != 8'h00 |-> !pixel_analog_oe_n)
    else $error("output released during readout");
  a_pixel_per_clock: assert property (
    !pixel_analog_oe_n && !$past(pixel_analog_oe_n) &&
    $changed(pixel_analog_out) |->
    $past(sensor_clk_en) || $past(sensor_clk_en, 2))
    else $error("pixel changed between sensor edges");
  a_end_high_z: assert property (
    sensor_clk_en && edge_cnt_r == 8'(PIXELS) |->
    ##[1:2] pixel_analog_oe_n)
    else $error("output not released at edge 129");
  a_idle_high_z: assert property (
    $fell(pixel_analog_oe_n) |-> edge_cnt_r == 8'h01)
    else $error("output driven outside readout");
  a_transfer_gap: assert property (
    $rose(start) |-> gap_r >= 12'(TRANSFER))
    else $error("start too soon after cycle end");
endmodule

// *** tb_linear_pixel_array_readout.sv ***
// Testbench joining sensor end and controller end through the link.
// Assumes the design files are compiled first.
`timescale 1ns/10ps
module tb_linear_pixel_array_readout;
  logic       clk;
  logic       rst;
  logic       go;
  logic [7:0] charge [128];
  logic       hold, integ_reset, integrating, busy, pixel_valid;
  logic [7:0] pixel_data, pixel_index;
  int         n_mismatch, checked, n_valid, edge_n, exp_idx;
  lpa_link_if #(.PIXEL_W(8)) link ();
  lpa_sensor u_lpa_sensor (.clk(clk), .rst(rst), .link(link),
    .pixel_charge(charge), .hold(hold), .integ_reset(integ_reset),
    .integrating(integrating));
  lpa_controller #(.TRANSFER(20)) u_lpa_controller (.clk(clk), .rst(rst),
    .link(link), .go(go), .busy(busy), .pixel_valid(pixel_valid),
    .pixel_data(pixel_data), .pixel_index(pixel_index));
  lpa_link_monitor #(.TRANSFER(20)) u_lpa_link_monitor (.clk(clk),
    .rst(rst), .sensor_clk_en(link.sensor_clk_en), .start(link.start),
    .pixel_analog_out(link.pixel_analog_out),
    .pixel_analog_oe_n(link.pixel_analog_oe_n));

  // Clock of 8 ns period.
  always #4 clk = ~clk;

  task automatic check_bit(string what, logic exp, logic got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_val(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wait_edge(int k);
    while (edge_n != k) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask

  // Watches the wire: each sensor edge still shows the previous pixel.
  always @(posedge clk) begin
    if (link.sensor_clk_en === 1'b1) begin
      if (edge_n >= 1 && edge_n <= 128)
        check_val("wire pixel", charge[edge_n-1], link.pixel_analog_out);
      if (link.start === 1'b1) begin
        check_bit("idle oe_n", 1'b1, link.pixel_analog_oe_n);
        edge_n <= 1;
        exp_idx = 0;
      end else if (edge_n != 0) begin
        edge_n <= edge_n + 1;
      end
    end
  end

  // Checks each captured pixel against the charge pattern.
  always @(posedge clk) begin
    if (pixel_valid === 1'b1) begin
      check_val("index", 8'(exp_idx), pixel_index);
      check_val("data", charge[exp_idx % 128], pixel_data);
      exp_idx++;
      n_valid++;
    end
  end

  // Two back-to-back cycles with go held high, then idle.
  initial begin
    clk = 0; rst = 1; go = 0; edge_n = 0; exp_idx = 0;
    n_mismatch = 0; checked = 0; n_valid = 0;
    for (int i = 0; i < 128; i++) charge[i] = 8'(i * 3 + 5);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check_bit("hold idle", 1'b0, hold);
    check_bit("integrating idle", 1'b1, integrating);
    go <= 1'b1;
    for (int c = 0; c < 2; c++) begin
      wait_edge(1);
      check_bit("hold", 1'b1, hold);
      check_bit("integ_reset", 1'b1, integ_reset);
      check_bit("integrating", 1'b0, integrating);
      wait_edge(18);
      check_bit("integ_reset late", 1'b1, integ_reset);
      wait_edge(19);
      check_bit("integ_reset off", 1'b0, integ_reset);
      check_bit("integrating on", 1'b1, integrating);
      wait_edge(129);
      check_bit("end oe_n", 1'b1, link.pixel_analog_oe_n);
      check_val("pixel count", 8'h80, 8'(n_valid));
      n_valid = 0;
    end
    go <= 1'b0;
    repeat (3000) @(posedge clk);
    check_bit("busy", 1'b0, busy);
    check_val("no extra pixels", 8'(n_valid), 8'h00);
    summarize;
  end

  // Cuts a hang short at 12000 clocks, about five thirds of the expected run.
  initial begin
    repeat (12000) @(posedge clk);
    n_mismatch++;
    summarize;
  end
endmodule
